/* src/cfgrg_consts.vh */
// Purpose: Constants for the converter configuration and status register bank
// Assumes: Byte-wide serial register port, one clock
// Notes:   Multi-byte registers are little endian, lowest address holds bits 7:0
//
// Contract
// - Provide 24-bit read-only sampled position of alignment edge versus device clock.
// - Hold 16-bit full-scale span code for all channels, reset 0xA000.
// - Span code 0x2000 is 500 mVPP minimum, 0xFFFF is 1000 mVPP maximum.
// - Power profile 0x46 is low power, 0x4B high performance and reset.
// - Timestamp control bit 0 enables timestamp input receiver, reset 0.
// - Timestamp control bit 1 selects low-voltage PECL receive mode, reset 0.
// - Reference clock output active only when its enable and synthesizer enable are 1.
// - Alignment delay selection is a 4-bit writable field choosing sampling delay.
`ifndef CFGRG_CONSTS_VH
`define CFGRG_CONSTS_VH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define CFGRG_ADDR_ALIGN_SEL   8'h29
`define CFGRG_ADDR_EDGE_POS0   8'h2c
`define CFGRG_ADDR_EDGE_POS1   8'h2d
`define CFGRG_ADDR_EDGE_POS2   8'h2e
`define CFGRG_ADDR_SPAN0       8'h30
`define CFGRG_ADDR_SPAN1       8'h31
`define CFGRG_ADDR_POWER1      8'h37
`define CFGRG_ADDR_TSTAMP      8'h3b
`define CFGRG_ADDR_REFOUT      8'h3c

// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define CFGRG_RST_SPAN         16'ha000
`define CFGRG_RST_POWER        8'h4b
`define CFGRG_RST_ALIGN_SEL    4'h0
`define CFGRG_RST_EDGE_POS     24'h000000
`define CFGRG_RST_TS_RECV      1'b0
`define CFGRG_RST_TS_PECL      1'b0
`define CFGRG_RST_REFOUT_EN    1'b1
`define CFGRG_CODE_LOW_POWER   8'h46
`define CFGRG_CODE_HIGH_PERF   8'h4b
`define CFGRG_SPAN_MIN_REC     16'h2000
`define CFGRG_SPAN_MAX         16'hffff

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CFGRG_BIT_TS_RECV      0
`define CFGRG_BIT_TS_PECL      1
`define CFGRG_BIT_REFOUT_EN    0
`define CFGRG_ALIGN_SEL_MSB    3

`endif

/* src/cfgrg_edge_capture.v */
// Purpose: Capture of the alignment edge position taps
// Assumes: Taps come from the sampling delay line, outside the clock domain
// Notes:   Two-stage synchroniser per tap; status frozen while capture is off
`timescale 1ns/1ns
`default_nettype none
`include "cfgrg_consts.vh"

module cfgrg_edge_capture #(
  parameter WIDTH = 24
) (
  // Clock and reset
  input  wire             clock,
  input  wire             rst_b,
  // Taps and control
  input  wire [WIDTH-1:0] edgeTaps,
  input  wire             captureEnable,
  // Status
  output reg  [WIDTH-1:0] edgePositionStatus
);

  reg [WIDTH-1:0] tapMeta;
  reg [WIDTH-1:0] tapSync;

  // ----------------------------------------
  // Synchroniser and capture
  // ----------------------------------------
  always @(posedge clock) begin
    if (!rst_b) begin
      tapMeta            <= {WIDTH{1'b0}};
      tapSync            <= {WIDTH{1'b0}};
      edgePositionStatus <= `CFGRG_RST_EDGE_POS;
    end else begin
      tapMeta <= edgeTaps;
      tapSync <= tapMeta;
      // Hold last result so software reads a stable value once capture stops
      if (captureEnable) begin
        edgePositionStatus <= tapSync;
      end
    end
  end

endmodule // cfgrg_edge_capture
`default_nettype wire

/* src/cfgrg_regs.v */
// Purpose: Configuration and status register bank of the quad converter
// Assumes: Byte register port driven by the serial front end on the same clock
// Notes:   Reads return registered data one cycle after the read strobe
`timescale 1ns/1ns
`default_nettype none
`include "cfgrg_consts.vh"

module cfgrg_regs #(
  parameter EDGE_W = 24
) (
  // Clock and reset
  input  wire              clock,
  input  wire              rst_b,
  // Register port
  input  wire [7:0]        regAddr,
  input  wire [7:0]        regWrData,
  input  wire              regWrEn,
  input  wire              regRdEn,
  output reg  [7:0]        regRdData,
  output reg               regRdValid,
  // Edge position sampling
  input  wire [EDGE_W-1:0] edgeTaps,
  input  wire              edgeCaptureEnable,
  // Synthesizer status
  input  wire              synthEnable,
  // Configuration outputs
  output reg  [15:0]       fullscaleSpanCode,
  output reg  [7:0]        powerProfileCode,
  output reg               lowPowerActive,
  output reg  [3:0]        alignmentDelaySelect,
  output reg               timestampReceiverEnable,
  output reg               timestampPeclMode,
  output reg               refClockOutEnable,
  output reg               refClockOutActive
);

  wire [EDGE_W-1:0] edgePositionStatus;
  reg               edgeSyncMeta;
  reg               edgeSyncOut;
  reg               synthMeta;
  reg               synthSync;
  reg  [7:0]        next_rdData;
  wire              wrAccepted;
  wire              wrSpanLow;
  wire              wrSpanHigh;
  wire              wrPower;
  wire              wrAlignSel;
  wire              wrTimestamp;
  wire              wrRefOut;

  // Match helper used by read and write decode
  function hit;
    input [7:0] addr;
    input [7:0] target;
    begin
      hit = (addr == target);
    end
  endfunction

  // Status window covers three byte addresses
  function isStatus;
    input [7:0] addr;
    begin
      isStatus = hit(addr, `CFGRG_ADDR_EDGE_POS0) |
                 hit(addr, `CFGRG_ADDR_EDGE_POS1) |
                 hit(addr, `CFGRG_ADDR_EDGE_POS2);
    end
  endfunction

  // ----------------------------------------
  // Edge position capture
  // ----------------------------------------
  // Capture enable and synthesizer enable come from other domains
  always @(posedge clock) begin
    if (!rst_b) begin
      edgeSyncMeta <= 1'b0;
      edgeSyncOut  <= 1'b0;
      synthMeta    <= 1'b0;
      synthSync    <= 1'b0;
    end else begin
      edgeSyncMeta <= edgeCaptureEnable;
      edgeSyncOut  <= edgeSyncMeta;
      synthMeta    <= synthEnable;
      synthSync    <= synthMeta;
    end
  end

  cfgrg_edge_capture #(
    .WIDTH (EDGE_W)
  ) u_capture (
    .clock              (clock),
    .rst_b              (rst_b),
    .edgeTaps           (edgeTaps),
    .captureEnable      (edgeSyncOut),
    .edgePositionStatus (edgePositionStatus)
  );

  // ----------------------------------------
  // Write decode
  // ----------------------------------------
  // Status bytes never reach a register strobe, so their writes fall away
  assign wrAccepted  = regWrEn & ~isStatus(regAddr);
  assign wrSpanLow   = wrAccepted & hit(regAddr, `CFGRG_ADDR_SPAN0);
  assign wrSpanHigh  = wrAccepted & hit(regAddr, `CFGRG_ADDR_SPAN1);
  assign wrPower     = wrAccepted & hit(regAddr, `CFGRG_ADDR_POWER1);
  assign wrAlignSel  = wrAccepted & hit(regAddr, `CFGRG_ADDR_ALIGN_SEL);
  assign wrTimestamp = wrAccepted & hit(regAddr, `CFGRG_ADDR_TSTAMP);
  assign wrRefOut    = wrAccepted & hit(regAddr, `CFGRG_ADDR_REFOUT);

  // ----------------------------------------
  // Full-scale span
  // ----------------------------------------
  // Bytes land independently; software writes both for a coherent code
  always @(posedge clock) begin
    if (!rst_b) begin
      fullscaleSpanCode <= `CFGRG_RST_SPAN;
    end else begin
      if (wrSpanLow) begin
        fullscaleSpanCode[7:0] <= regWrData;
      end
      if (wrSpanHigh) begin
        // Codes under the recommended minimum are stored as written
        fullscaleSpanCode[15:8] <= regWrData;
      end
    end
  end

  // ----------------------------------------
  // Power profile
  // ----------------------------------------
  always @(posedge clock) begin
    if (!rst_b) begin
      powerProfileCode <= `CFGRG_RST_POWER;
    end else if (wrPower) begin
      // Reserved codes are stored; only the low power code changes mode
      powerProfileCode <= regWrData;
    end
  end

  // ----------------------------------------
  // Alignment delay selection
  // ----------------------------------------
  always @(posedge clock) begin
    if (!rst_b) begin
      alignmentDelaySelect <= `CFGRG_RST_ALIGN_SEL;
    end else if (wrAlignSel) begin
      alignmentDelaySelect <= regWrData[`CFGRG_ALIGN_SEL_MSB:0];
    end
  end

  // ----------------------------------------
  // Timestamp input control
  // ----------------------------------------
  // Reserved bits are not stored and read back as zero
  always @(posedge clock) begin
    if (!rst_b) begin
      timestampReceiverEnable <= `CFGRG_RST_TS_RECV;
      timestampPeclMode       <= `CFGRG_RST_TS_PECL;
    end else if (wrTimestamp) begin
      timestampReceiverEnable <= regWrData[`CFGRG_BIT_TS_RECV];
      timestampPeclMode       <= regWrData[`CFGRG_BIT_TS_PECL];
    end
  end

  // ----------------------------------------
  // Reference clock output control
  // ----------------------------------------
  // Comes up set so the reference clock runs before any register write once the synchronised synthesizer enable is high
  always @(posedge clock) begin
    if (!rst_b) begin
      refClockOutEnable <= `CFGRG_RST_REFOUT_EN;
    end else if (wrRefOut) begin
      refClockOutEnable <= regWrData[`CFGRG_BIT_REFOUT_EN];
    end
  end

  // ----------------------------------------
  // Derived controls
  // ----------------------------------------
  always @(posedge clock) begin
    if (!rst_b) begin
      lowPowerActive <= 1'b0;
    end else begin
      lowPowerActive <= (powerProfileCode == `CFGRG_CODE_LOW_POWER);
    end
  end

  // Gated by the synchronised synthesizer enable, one extra flop of latency
  always @(posedge clock) begin
    if (!rst_b) begin
      refClockOutActive <= 1'b0;
    end else begin
      refClockOutActive <= refClockOutEnable & synthSync;
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  always @* begin
    next_rdData = 8'h00;
    case (1'b1)
      hit(regAddr, `CFGRG_ADDR_EDGE_POS0): next_rdData = edgePositionStatus[7:0];
      hit(regAddr, `CFGRG_ADDR_EDGE_POS1): next_rdData = edgePositionStatus[15:8];
      hit(regAddr, `CFGRG_ADDR_EDGE_POS2): next_rdData = edgePositionStatus[23:16];
      hit(regAddr, `CFGRG_ADDR_SPAN0):     next_rdData = fullscaleSpanCode[7:0];
      hit(regAddr, `CFGRG_ADDR_SPAN1):     next_rdData = fullscaleSpanCode[15:8];
      hit(regAddr, `CFGRG_ADDR_POWER1):    next_rdData = powerProfileCode;
      hit(regAddr, `CFGRG_ADDR_ALIGN_SEL): next_rdData = {4'h0, alignmentDelaySelect};
      hit(regAddr, `CFGRG_ADDR_TSTAMP):    next_rdData = {6'h00, timestampPeclMode, timestampReceiverEnable};
      hit(regAddr, `CFGRG_ADDR_REFOUT):    next_rdData = {7'h00, refClockOutEnable};
      default:                             next_rdData = 8'h00;
    endcase
  end

  always @(posedge clock) begin
    if (!rst_b) begin
      regRdData  <= 8'h00;
      regRdValid <= 1'b0;
    end else begin
      regRdValid <= regRdEn;
      if (regRdEn) begin
        regRdData <= next_rdData;
      end
    end
  end

endmodule // cfgrg_regs
`default_nettype wire

/* verification/cfgrg_regs_props.sv */
// Purpose: Port checks for cfgrg_regs
// Assumes: Synchronous active-low reset, one clock
// Notes:   Bound to every cfgrg_regs instance
`timescale 1ns/1ns
`default_nettype none
module cfgrg_regs_props (
  // Clock, reset, port
  input wire logic        clock, rst_b, regWrEn, regRdEn, regRdValid, synthEnable,
  input wire logic [7:0]  regAddr, regWrData, powerProfileCode,
  // Outputs
  input wire logic [15:0] fullscaleSpanCode,
  input wire logic [3:0]  alignmentDelaySelect,
  input wire logic        lowPowerActive, timestampReceiverEnable, timestampPeclMode,
  input wire logic        refClockOutEnable, refClockOutActive
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  a_span_low: assert property (regWrEn && regAddr == 8'h30 |=> fullscaleSpanCode[7:0] == $past(regWrData))
    else $error("span low byte");
  a_span_high: assert property (regWrEn && regAddr == 8'h31 |=> fullscaleSpanCode[15:8] == $past(regWrData))
    else $error("span high byte");
  a_power_code: assert property (regWrEn && regAddr == 8'h37 |=> powerProfileCode == $past(regWrData))
    else $error("power code");
  a_low_power: assert property (lowPowerActive == ($past(powerProfileCode) == 8'h46))
    else $error("low power flag");
  a_ts_recv: assert property (regWrEn && regAddr == 8'h3b |=> timestampReceiverEnable == $past(regWrData[0]))
    else $error("receiver enable");
  a_ts_pecl: assert property (regWrEn && regAddr == 8'h3b |=> timestampPeclMode == $past(regWrData[1]))
    else $error("pecl mode");
  a_align_sel: assert property (regWrEn && regAddr == 8'h29 |=> alignmentDelaySelect == $past(regWrData[3:0]))
    else $error("align select");
  a_refout_gate: assert property (refClockOutActive |-> $past(refClockOutEnable))
    else $error("ref out without enable");
  a_refout_on: assert property ((refClockOutEnable && synthEnable) [*4] |-> refClockOutActive)
    else $error("ref out not active");
  a_read_valid: assert property (regRdValid == $past(regRdEn && rst_b))
    else $error("read valid timing");
  a_reset_vals: assert property ($rose(rst_b) |-> refClockOutEnable && fullscaleSpanCode == 16'ha000)
    else $error("reset values");
endmodule // cfgrg_regs_props
bind cfgrg_regs cfgrg_regs_props u_props (.clock(clock), .rst_b(rst_b), .regWrEn(regWrEn),
  .regRdEn(regRdEn), .regRdValid(regRdValid), .synthEnable(synthEnable), .regAddr(regAddr),
  .regWrData(regWrData), .powerProfileCode(powerProfileCode), .fullscaleSpanCode(fullscaleSpanCode),
  .alignmentDelaySelect(alignmentDelaySelect), .lowPowerActive(lowPowerActive),
  .timestampReceiverEnable(timestampReceiverEnable), .timestampPeclMode(timestampPeclMode),
  .refClockOutEnable(refClockOutEnable), .refClockOutActive(refClockOutActive));
`default_nettype wire

/* verification/testbench.sv */
// Purpose: Self-checking bench for cfgrg_regs
// Assumes: Byte strobes one cycle wide, read answer one cycle later
// Notes:   Edge bytes read while capture is off, no shadowing
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic        clock = 0, rst_b = 0, regWrEn = 0, regRdEn = 0, edgeCaptureEnable = 0, synthEnable = 0;
  logic [7:0]  regAddr = 8'h00, regWrData = 8'h00, regRdData, powerProfileCode;
  logic [23:0] edgeTaps = 24'h000000;
  logic [15:0] fullscaleSpanCode;
  logic [3:0]  alignmentDelaySelect;
  logic        regRdValid, lowPowerActive, timestampReceiverEnable, timestampPeclMode;
  logic        refClockOutEnable, refClockOutActive;
  int          nMismatch = 0, checks = 0;
  always #10 clock = ~clock;
  cfgrg_regs dut (.clock(clock), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .regRdValid(regRdValid),
    .edgeTaps(edgeTaps), .edgeCaptureEnable(edgeCaptureEnable), .synthEnable(synthEnable),
    .fullscaleSpanCode(fullscaleSpanCode), .powerProfileCode(powerProfileCode),
    .lowPowerActive(lowPowerActive), .alignmentDelaySelect(alignmentDelaySelect),
    .timestampReceiverEnable(timestampReceiverEnable), .timestampPeclMode(timestampPeclMode),
    .refClockOutEnable(refClockOutEnable), .refClockOutActive(refClockOutActive));
  task results;
    $display("checks %0d mismatches %0d", checks, nMismatch);
    if (nMismatch == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    checks++;
    if (seen !== exp) begin
      nMismatch++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock) begin regAddr <= a; regWrData <= d; regWrEn <= 1'b1; end
    @(posedge clock) regWrEn <= 1'b0;
    #1;
  endtask
  // Bounded wait; a lost answer ends the run
  task rd(input logic [7:0] a, input logic [7:0] exp);
    int i;
    i = 0;
    @(posedge clock) begin regAddr <= a; regRdEn <= 1'b1; end
    @(posedge clock) regRdEn <= 1'b0;
    #1;
    while (regRdValid !== 1'b1 && i < 4) begin @(posedge clock); #1; i++; end
    if (regRdValid !== 1'b1) begin nMismatch++; results; end
    else chk("regRdData", regRdData, exp);
  endtask
  task resetValues;
    rd(8'h31, 8'ha0);
    rd(8'h37, 8'h4b);
    rd(8'h3b, 8'h00);
    rd(8'h3c, 8'h01);
    rd(8'h2c, 8'h00);
    rd(8'h29, 8'h00);
    chk("refClockOutActive", refClockOutActive, 0);
  endtask
  task spanCodes;
    logic [15:0] v [0:2];
    v = '{16'h2000, 16'hffff, 16'h1fff};
    for (int i = 0; i < 3; i++) begin
      wr(8'h30, v[i][7:0]);
      wr(8'h31, v[i][15:8]);
      chk("fullscaleSpanCode", fullscaleSpanCode, v[i]);
      rd(8'h30, v[i][7:0]);
    end
  endtask
  task powerCodes;
    logic [7:0] c [0:2];
    c = '{8'h46, 8'h47, 8'h4b};
    // Bench stands for a slow rate with link and calibration off; companions live elsewhere
    for (int i = 0; i < 3; i++) begin
      wr(8'h37, c[i]);
      chk("powerProfileCode", powerProfileCode, c[i]);
      @(posedge clock); #1;
      chk("lowPowerActive", lowPowerActive, c[i] == 8'h46);
      rd(8'h37, c[i]);
    end
  endtask
  task timestampBits;
    wr(8'h3b, 8'h03);
    chk("timestampReceiverEnable", timestampReceiverEnable, 1);
    rd(8'h3b, 8'h03);
    wr(8'h3b, 8'h02);
    chk("timestampReceiverEnable", timestampReceiverEnable, 0);
    chk("timestampPeclMode", timestampPeclMode, 1);
  endtask
  task refOut;
    @(posedge clock) synthEnable <= 1'b1;
    repeat (2) @(posedge clock);
    #1 chk("refClockOutActive", refClockOutActive, 0);
    @(posedge clock); #1 chk("refClockOutActive", refClockOutActive, 1);
    wr(8'h3c, 8'h00);
    chk("refClockOutEnable", refClockOutEnable, 0);
    @(posedge clock); #1 chk("refClockOutActive", refClockOutActive, 0);
    wr(8'h3c, 8'h01);
    chk("refClockOutEnable", refClockOutEnable, 1);
    @(posedge clock) synthEnable <= 1'b0;
  endtask
  task edgeCapture;
    @(posedge clock) begin edgeTaps <= 24'ha5c3e1; edgeCaptureEnable <= 1'b1; end
    repeat (8) @(posedge clock);
    edgeCaptureEnable <= 1'b0;
    repeat (4) @(posedge clock);
    edgeTaps <= 24'h5a3c1e;
    wr(8'h2c, 8'hff);
    rd(8'h2c, 8'he1);
    rd(8'h2d, 8'hc3);
    rd(8'h2e, 8'ha5);
  endtask
  task alignMisc;
    wr(8'h29, 8'h0f);
    chk("alignmentDelaySelect", alignmentDelaySelect, 4'hf);
    rd(8'h50, 8'h00);
  endtask
  task midReset;
    @(posedge clock) rst_b <= 1'b0;
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    resetValues;
  endtask
  initial begin
    repeat (10) @(posedge clock);
    rst_b <= 1'b1;
    resetValues;
    spanCodes;
    powerCodes;
    timestampBits;
    refOut;
    edgeCapture;
    alignMisc;
    midReset;
    results;
  end
endmodule // testbench
`default_nettype wire
